// >>> verilog/swing_length_count_unit.sv
// Purpose: Swing-frequency modulator, fixed-length meter and pulse counter
// Assumes: APB slave, zero wait states; pulse inputs synchronous to ref_clk
// Notes: Swing output is recomputed every cycle and registered once
// Function
// R1: Swing output around set frequency centre
// R2: Zero amplitude gives plain set frequency
// R3: Mode bit selects central or maximum base
// R4: Central mode: amplitude equals set times percentage
// R5: Maximum mode: amplitude equals maximum times percentage
// R6: Jump equals amplitude times jump percentage
// R7: Clamp swing output between lower and upper
// R8: Full swing cycle lasts the cycle time
// R9: Rise time is cycle times coefficient
// R10: Length is pulse count over pulses-per-metre
// R11: Length-reached flag when length exceeds set
// R12: Length clear input resets the measurement
// R13: Installer feeds length pulses, fast ones high-speed
// R14: Installer feeds count pulses, fast ones high-speed
// R15: Set count reached: flag on, counting stops
// R16: Designated count reached flag, counting continues
// R17: Designated count not above set count
// R18: Sixteen-bit thresholds compared every clock cycle
// R19: Step back by jump at each reversal
`timescale 1ns/1ns
module swing_length_count_unit #(
	parameter int unsigned TICK_CYCLES = swing_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] setFrequencySource,
	input wire logic lengthPulseInput,
	input wire logic countPulseInput,
	input wire logic highSpeedPulseInput,
	input wire logic lengthClear,
	output logic [15:0] outFrequency,
	output logic lengthReached,
	output logic setCountReached,
	output logic designatedCountReached
);
	////////////////////////////////////////////////////////////////////////////////
	// Register bus

	swing_pkg::unit_cfg_type cfg_reg, cfg_next;
	logic [31:0] prdata_reg, prdata_next;
	logic wrEn;
	logic rdSetup;
	logic lenClrWr;
	logic cntClrWr;
	logic [31:0] readWord;
	logic [15:0] actualLength_reg, actualLength_next;
	logic [15:0] count_reg, count_next;
	logic [15:0] outFreq_reg, outFreq_next;
	logic lenFlag_reg, lenFlag_next;
	logic setFlag_reg, setFlag_next;
	logic desFlag_reg, desFlag_next;
	logic rising;

	function automatic logic addrHit(input logic [7:0] a);
		return (a <= swing_pkg::OFS_OUTF) && (a[1:0] == 2'b00);
	endfunction

	assign wrEn = psel & penable & pwrite & addrHit(paddr);
	assign rdSetup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addrHit(paddr);
	assign prdata = prdata_reg;
	assign lenClrWr = wrEn && (paddr == swing_pkg::OFS_CTRL) && pwdata[swing_pkg::CTL_LEN_CLR];
	assign cntClrWr = wrEn && (paddr == swing_pkg::OFS_CTRL) && pwdata[swing_pkg::CTL_CNT_CLR];

	// Configuration writes
	always_comb begin
		cfg_next = cfg_reg;
		if (wrEn) begin
			unique case (paddr)
				swing_pkg::OFS_MODE: begin
					cfg_next.relMax = pwdata[swing_pkg::MODE_RELMAX]; // [R3]
					cfg_next.hsToLength = pwdata[swing_pkg::MODE_HS_LEN];
					cfg_next.hsToCount = pwdata[swing_pkg::MODE_HS_CNT];
				end
				swing_pkg::OFS_AMP: cfg_next.ampPct = pwdata[15:0];
				swing_pkg::OFS_JUMP: cfg_next.jumpPct = pwdata[15:0];
				swing_pkg::OFS_CYCLE: cfg_next.cycleTime = pwdata[15:0];
				swing_pkg::OFS_RISE: cfg_next.riseCoef = pwdata[15:0];
				swing_pkg::OFS_SETLEN: cfg_next.setLength = pwdata[15:0];
				swing_pkg::OFS_PPM: cfg_next.pulsesPerMeter = pwdata[15:0];
				swing_pkg::OFS_SETCNT: cfg_next.setCount = pwdata[15:0];
				swing_pkg::OFS_DESCNT: cfg_next.designatedCount = pwdata[15:0];
				swing_pkg::OFS_MAXF: cfg_next.maxOutputFrequency = pwdata[15:0];
				swing_pkg::OFS_UPPER: cfg_next.upperLimit = pwdata[15:0];
				swing_pkg::OFS_LOWER: cfg_next.lowerLimit = pwdata[15:0];
				default: begin
					// Read-only and command words store nothing
				end
			endcase
		end
	end

	// Read mux; data latched in the setup cycle so it is stable in access
	always_comb begin
		readWord = 32'h0000_0000;
		unique case (paddr)
			swing_pkg::OFS_MODE: readWord = {29'h0, cfg_reg.hsToCount, cfg_reg.hsToLength, cfg_reg.relMax};
			swing_pkg::OFS_AMP: readWord = {16'h0000, cfg_reg.ampPct};
			swing_pkg::OFS_JUMP: readWord = {16'h0000, cfg_reg.jumpPct};
			swing_pkg::OFS_CYCLE: readWord = {16'h0000, cfg_reg.cycleTime};
			swing_pkg::OFS_RISE: readWord = {16'h0000, cfg_reg.riseCoef};
			swing_pkg::OFS_SETLEN: readWord = {16'h0000, cfg_reg.setLength};
			swing_pkg::OFS_ACTLEN: readWord = {16'h0000, actualLength_reg};
			swing_pkg::OFS_PPM: readWord = {16'h0000, cfg_reg.pulsesPerMeter};
			swing_pkg::OFS_SETCNT: readWord = {16'h0000, cfg_reg.setCount};
			swing_pkg::OFS_DESCNT: readWord = {16'h0000, cfg_reg.designatedCount};
			swing_pkg::OFS_COUNT: readWord = {16'h0000, count_reg};
			swing_pkg::OFS_MAXF: readWord = {16'h0000, cfg_reg.maxOutputFrequency};
			swing_pkg::OFS_UPPER: readWord = {16'h0000, cfg_reg.upperLimit};
			swing_pkg::OFS_LOWER: readWord = {16'h0000, cfg_reg.lowerLimit};
			swing_pkg::OFS_STATUS: readWord = {28'h0, rising, desFlag_reg, setFlag_reg, lenFlag_reg};
			swing_pkg::OFS_OUTF: readWord = {16'h0000, outFreq_reg};
			default: readWord = 32'h0000_0000;
		endcase
		prdata_next = rdSetup ? readWord : prdata_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cfg_reg <= '{relMax: 1'b0, hsToLength: 1'b0, hsToCount: 1'b0, ampPct: 16'h0000,
				jumpPct: 16'h0000, cycleTime: swing_pkg::RST_CYCLE, riseCoef: swing_pkg::RST_RISE,
				maxOutputFrequency: swing_pkg::RST_MAXF, upperLimit: swing_pkg::RST_UPPER,
				lowerLimit: swing_pkg::RST_LOWER, setLength: swing_pkg::RST_SETLEN,
				pulsesPerMeter: swing_pkg::RST_PPM, setCount: swing_pkg::RST_SETCNT,
				designatedCount: swing_pkg::RST_DESCNT};
			prdata_reg <= 32'h0000_0000;
		end else begin
			cfg_reg <= cfg_next;
			prdata_reg <= prdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Swing modulator

	logic [15:0] position;
	logic [15:0] riseTicks;
	logic [15:0] fallTicks;
	logic tick;
	logic [15:0] baseFreq;
	logic [15:0] swingAmplitudeAbs;
	logic [15:0] jumpPct;
	logic [15:0] jumpAbs;
	logic [16:0] span;
	logic [31:0] ramp;
	logic signed [19:0] offset;
	logic signed [19:0] rawFreq;
	logic swingActive;

	swing_phase #(
		.TICK_CYCLES(TICK_CYCLES)
	) phaseGen (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.cycleTime(cfg_reg.cycleTime),
		.riseCoef(cfg_reg.riseCoef),
		.rising(rising),
		.position(position),
		.riseTicks(riseTicks),
		.fallTicks(fallTicks),
		.tick(tick)
	); // [R8] [R9]

	// Amplitude, jump and triangle offset; in central mode amplitude follows the live centre
	always_comb begin
		baseFreq = cfg_reg.relMax ? cfg_reg.maxOutputFrequency : setFrequencySource; // [R3]
		swingAmplitudeAbs = swing_pkg::sat16(swing_pkg::mulDiv({16'h0000, baseFreq}, cfg_reg.ampPct,
			swing_pkg::PERMILLE)); // [R4] [R5]
		jumpPct = (cfg_reg.jumpPct > swing_pkg::JUMP_MAX) ? swing_pkg::JUMP_MAX : cfg_reg.jumpPct;
		jumpAbs = swing_pkg::sat16(swing_pkg::mulDiv({16'h0000, swingAmplitudeAbs}, jumpPct,
			swing_pkg::PERMILLE)); // [R6]
		span = {swingAmplitudeAbs, 1'b0} - {1'b0, jumpAbs};
		ramp = swing_pkg::mulDiv({15'h0000, span}, position, (rising ? riseTicks : fallTicks) - 16'h0001);
		// Slope starts one jump inside the peak it leaves and reaches the opposite peak on its last step
		if (rising) begin
			offset = $signed({4'h0, jumpAbs}) - $signed({4'h0, swingAmplitudeAbs}) + $signed(ramp[19:0]); // [R19]
		end else begin
			offset = $signed({4'h0, swingAmplitudeAbs}) - $signed({4'h0, jumpAbs}) - $signed(ramp[19:0]); // [R19]
		end
		rawFreq = $signed({4'h0, setFrequencySource}) + offset; // [R1]
		swingActive = (cfg_reg.ampPct != 16'h0000) && (cfg_reg.cycleTime != 16'h0000);
		outFreq_next = setFrequencySource; // [R2]
		if (swingActive) begin
			// Upper limit checked last so a crossed limit pair favours the ceiling
			if (rawFreq < $signed({4'h0, cfg_reg.lowerLimit})) begin
				outFreq_next = cfg_reg.lowerLimit; // [R7]
			end else begin
				outFreq_next = rawFreq[15:0];
			end
			if (rawFreq > $signed({4'h0, cfg_reg.upperLimit})) begin
				outFreq_next = cfg_reg.upperLimit; // [R7]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Length meter and counter

	logic lengthSource;
	logic countSource;
	logic lengthEdge;
	logic countEdge;
	logic lengthClr;
	logic countAtSet;
	logic [31:0] pulseCount_reg, pulseCount_next;

	assign lengthSource = cfg_reg.hsToLength ? highSpeedPulseInput : lengthPulseInput; // [R13]
	assign countSource = cfg_reg.hsToCount ? highSpeedPulseInput : countPulseInput; // [R14]

	pulse_edge lengthDet (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pulseIn(lengthSource),
		.pulseRise(lengthEdge)
	);

	pulse_edge countDet (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pulseIn(countSource),
		.pulseRise(countEdge)
	);

	// Pulse accumulation; a pulse in the clearing cycle is kept
	always_comb begin
		lengthClr = lengthClear | lenClrWr;
		pulseCount_next = pulseCount_reg;
		if (lengthClr) begin
			pulseCount_next = lengthEdge ? 32'h0000_0001 : 32'h0000_0000; // [R12]
		end else if (lengthEdge && pulseCount_reg != 32'hffff_ffff) begin
			pulseCount_next = pulseCount_reg + 32'h0000_0001;
		end
		actualLength_next = swing_pkg::sat16(swing_pkg::mulDiv(pulseCount_reg, swing_pkg::TENTHS,
			cfg_reg.pulsesPerMeter)); // [R10]
		lenFlag_next = actualLength_reg > cfg_reg.setLength; // [R11] [R18]
		countAtSet = count_reg >= cfg_reg.setCount;
		count_next = count_reg;
		if (cntClrWr) begin
			count_next = countEdge ? 16'h0001 : 16'h0000;
		end else if (countEdge && !countAtSet) begin
			count_next = count_reg + 16'h0001; // [R15]
		end
		setFlag_next = countAtSet; // [R15] [R18]
		// Flag is raised by a designated value above the set value only if the set value is lowered below a count already reached, since counting stops at the set value
		desFlag_next = count_reg >= cfg_reg.designatedCount; // [R16] [R17]
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pulseCount_reg <= 32'h0000_0000;
			actualLength_reg <= 16'h0000;
			count_reg <= 16'h0000;
			outFreq_reg <= 16'h0000;
			lenFlag_reg <= 1'b0;
			setFlag_reg <= 1'b0;
			desFlag_reg <= 1'b0;
		end else begin
			pulseCount_reg <= pulseCount_next;
			actualLength_reg <= actualLength_next;
			count_reg <= count_next;
			outFreq_reg <= outFreq_next;
			lenFlag_reg <= lenFlag_next;
			setFlag_reg <= setFlag_next;
			desFlag_reg <= desFlag_next;
		end
	end

	assign outFrequency = outFreq_reg;
	assign lengthReached = lenFlag_reg;
	assign setCountReached = setFlag_reg;
	assign designatedCountReached = desFlag_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_slopeTurn;
		rising ##1 !rising;
	endsequence

	sequence s_quietCount;
		!countEdge && !cntClrWr;
	endsequence

	property p_noSwing;
		@(posedge ref_clk) disable iff (!reset_n)
		(cfg_reg.ampPct == 16'h0000) |=> (outFrequency == $past(setFrequencySource));
	endproperty
	a_noSwing: assert property (p_noSwing) else $error("output differs from set frequency with zero amplitude"); // [R2]

	property p_clamp;
		@(posedge ref_clk) disable iff (!reset_n)
		(swingActive && cfg_reg.lowerLimit <= cfg_reg.upperLimit) |=>
			(outFrequency <= $past(cfg_reg.upperLimit)) && (outFrequency >= $past(cfg_reg.lowerLimit));
	endproperty
	a_clamp: assert property (p_clamp) else $error("swing output outside frequency limits"); // [R7]

	property p_maxBase;
		@(posedge ref_clk) disable iff (!reset_n)
		cfg_reg.relMax |-> (swingAmplitudeAbs == swing_pkg::sat16(32'(cfg_reg.maxOutputFrequency *
			cfg_reg.ampPct / 1000)));
	endproperty
	a_maxBase: assert property (p_maxBase) else $error("fixed amplitude not taken from maximum frequency"); // [R5]

	property p_jumpAtTop;
		@(posedge ref_clk) disable iff (!reset_n)
		s_slopeTurn |-> (offset == $signed({4'h0, swingAmplitudeAbs}) - $signed({4'h0, jumpAbs}));
	endproperty
	a_jumpAtTop: assert property (p_jumpAtTop) else $error("falling slope did not start one jump below peak"); // [R19]

	property p_lengthFlag;
		@(posedge ref_clk) disable iff (!reset_n)
		(actualLength_reg > cfg_reg.setLength) ##1 $stable(actualLength_reg) |-> lengthReached;
	endproperty
	a_lengthFlag: assert property (p_lengthFlag) else $error("length reached not raised"); // [R11]

	property p_lengthClear;
		@(posedge ref_clk) disable iff (!reset_n)
		(lengthClear && !lengthEdge) |=> (pulseCount_reg == 32'h0000_0000);
	endproperty
	a_lengthClear: assert property (p_lengthClear) else $error("length measurement not cleared"); // [R12]

	property p_countStops;
		@(posedge ref_clk) disable iff (!reset_n)
		(countAtSet && !cntClrWr) |=> $stable(count_reg);
	endproperty
	a_countStops: assert property (p_countStops) else $error("counter moved past set count"); // [R15]

	property p_countFlag;
		@(posedge ref_clk) disable iff (!reset_n)
		countAtSet ##1 s_quietCount |-> setCountReached;
	endproperty
	a_countFlag: assert property (p_countFlag) else $error("set count reached not raised"); // [R15]

	property p_designated;
		@(posedge ref_clk) disable iff (!reset_n)
		(count_reg >= cfg_reg.designatedCount && !countAtSet && countEdge && !cntClrWr) |=>
			designatedCountReached && (count_reg == $past(count_reg) + 16'h0001);
	endproperty
	a_designated: assert property (p_designated) else $error("designated flag or continued count wrong"); // [R16]
endmodule

// >>> verilog/swing_pkg.sv
// Purpose: Shared constants and types of the swing, length and count unit
// Assumes: Frequencies in 0.01 Hz, percentages in 0.1 %, times in 0.1 s
// Notes: Register offsets are byte addresses on the APB slave
package swing_pkg;
	// Clock rate and the swing time base
	localparam int unsigned CLK_FREQ_HZ = 20000000;
	localparam int unsigned TICK_TIME_MS = 100;
	localparam int unsigned TICK_CYCLES = TICK_TIME_MS * (CLK_FREQ_HZ / 1000);

	// Scale factors
	localparam logic [15:0] PERMILLE = 16'h03e8;
	localparam logic [15:0] JUMP_MAX = 16'h01f4;
	localparam logic [15:0] TENTHS = 16'h000a;

	// Register offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_AMP = 8'h04;
	localparam logic [7:0] OFS_JUMP = 8'h08;
	localparam logic [7:0] OFS_CYCLE = 8'h0c;
	localparam logic [7:0] OFS_RISE = 8'h10;
	localparam logic [7:0] OFS_SETLEN = 8'h14;
	localparam logic [7:0] OFS_ACTLEN = 8'h18;
	localparam logic [7:0] OFS_PPM = 8'h1c;
	localparam logic [7:0] OFS_SETCNT = 8'h20;
	localparam logic [7:0] OFS_DESCNT = 8'h24;
	localparam logic [7:0] OFS_COUNT = 8'h28;
	localparam logic [7:0] OFS_MAXF = 8'h2c;
	localparam logic [7:0] OFS_UPPER = 8'h30;
	localparam logic [7:0] OFS_LOWER = 8'h34;
	localparam logic [7:0] OFS_CTRL = 8'h38;
	localparam logic [7:0] OFS_STATUS = 8'h3c;
	localparam logic [7:0] OFS_OUTF = 8'h40;

	// Field positions
	localparam int MODE_RELMAX = 0;
	localparam int MODE_HS_LEN = 1;
	localparam int MODE_HS_CNT = 2;
	localparam int CTL_LEN_CLR = 0;
	localparam int CTL_CNT_CLR = 1;
	localparam int ST_LEN = 0;
	localparam int ST_SET = 1;
	localparam int ST_DES = 2;
	localparam int ST_RISE = 3;

	// Reset values
	localparam logic [15:0] RST_CYCLE = 16'h0064;
	localparam logic [15:0] RST_RISE = 16'h01f4;
	localparam logic [15:0] RST_SETLEN = 16'h03e8;
	localparam logic [15:0] RST_PPM = 16'h03e8;
	localparam logic [15:0] RST_SETCNT = 16'h03e8;
	localparam logic [15:0] RST_DESCNT = 16'h03e8;
	localparam logic [15:0] RST_MAXF = 16'h1388;
	localparam logic [15:0] RST_UPPER = 16'h1388;
	localparam logic [15:0] RST_LOWER = 16'h0000;

	typedef struct packed {
		logic relMax;
		logic hsToLength;
		logic hsToCount;
		logic [15:0] ampPct;
		logic [15:0] jumpPct;
		logic [15:0] cycleTime;
		logic [15:0] riseCoef;
		logic [15:0] maxOutputFrequency;
		logic [15:0] upperLimit;
		logic [15:0] lowerLimit;
		logic [15:0] setLength;
		logic [15:0] pulsesPerMeter;
		logic [15:0] setCount;
		logic [15:0] designatedCount;
	} unit_cfg_type;

	// Scaled product; a zero divisor yields zero
	function automatic logic [31:0] mulDiv(input logic [31:0] a, input logic [15:0] b, input logic [15:0] d);
		logic [47:0] p;
		p = a * b;
		return (d == 16'h0000) ? 32'h0000_0000 : 32'(p / {32'h0000_0000, d});
	endfunction

	function automatic logic [15:0] sat16(input logic [31:0] v);
		return (v > 32'h0000_ffff) ? 16'hffff : v[15:0];
	endfunction
endpackage

// >>> verilog/pulse_edge.sv
// Purpose: Rising-edge detector for a machine pulse input
// Assumes: Input already synchronous to ref_clk
// Notes: One-cycle pulse per rising edge
`timescale 1ns/1ns
module pulse_edge (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic pulseIn,
	output logic pulseRise
);
	logic level_reg;
	logic level_next;

	// Previous level
	always_comb begin
		level_next = pulseIn;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			level_reg <= 1'b0;
		end else begin
			level_reg <= level_next;
		end
	end

	assign pulseRise = pulseIn & ~level_reg;
endmodule

// >>> verilog/swing_phase.sv
// Purpose: Triangle phase sequencer of the swing modulator
// Assumes: Cycle time in 0.1 s, rise coefficient in 0.1 %
// Notes: Position counts time-base ticks inside the current slope
`timescale 1ns/1ns
module swing_phase #(
	parameter int unsigned TICK_CYCLES = swing_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [15:0] cycleTime,
	input wire logic [15:0] riseCoef,
	output logic rising,
	output logic [15:0] position,
	output logic [15:0] riseTicks,
	output logic [15:0] fallTicks,
	output logic tick
);
	typedef enum logic {PH_RISE, PH_FALL} phase_type;

	phase_type phase_reg, phase_next;
	logic [31:0] prescale_reg, prescale_next;
	logic [15:0] pos_reg, pos_next;
	logic [15:0] limit;

	// Slope lengths and slope sequencing
	always_comb begin
		riseTicks = swing_pkg::sat16(swing_pkg::mulDiv({16'h0000, cycleTime}, riseCoef, swing_pkg::PERMILLE));
		if (riseTicks > cycleTime) begin
			riseTicks = cycleTime;
		end
		fallTicks = cycleTime - riseTicks;
		tick = (prescale_reg == 32'(TICK_CYCLES - 1));
		prescale_next = tick ? 32'h0000_0000 : prescale_reg + 32'h0000_0001;
		limit = (phase_reg == PH_RISE) ? riseTicks : fallTicks;
		phase_next = phase_reg;
		pos_next = pos_reg;
		if (cycleTime == 16'h0000) begin
			phase_next = PH_RISE;
			pos_next = 16'h0000;
		end else if (limit == 16'h0000 || (tick && (pos_reg + 16'h0001) >= limit)) begin
			// Zero-length slope is skipped so the other slope fills the cycle
			phase_next = (phase_reg == PH_RISE) ? PH_FALL : PH_RISE;
			pos_next = 16'h0000;
		end else if (tick) begin
			pos_next = pos_reg + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			phase_reg <= PH_RISE;
			prescale_reg <= 32'h0000_0000;
			pos_reg <= 16'h0000;
		end else begin
			phase_reg <= phase_next;
			prescale_reg <= prescale_next;
			pos_reg <= pos_next;
		end
	end

	assign rising = (phase_reg == PH_RISE);
	assign position = pos_reg;
endmodule

// >>> verif/machine_pulse_model.sv
// Purpose: Model of the machine pulse sensors feeding the unit
// Assumes: Pulse lines idle low, sensors synchronous to ref_clk
// Notes: Gap input slows the train to test a slow sensor
`timescale 1ns/1ns
module machine_pulse_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [7:0] burst,
	input wire logic [3:0] gap,
	output logic pulseOut,
	output logic busy
);
	logic [7:0] left;
	logic [3:0] waitCnt;

	// Each pulse is high one clock and low at least one clock, the fastest legal train
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			pulseOut <= 1'b0;
			left <= 8'h00;
			waitCnt <= 4'h0;
		end else if (pulseOut) begin
			pulseOut <= 1'b0;
			waitCnt <= gap;
		end else if (waitCnt != 4'h0) begin
			waitCnt <= waitCnt - 4'h1;
		end else if (left != 8'h00) begin
			pulseOut <= 1'b1;
			left <= left - 8'h01;
		end else if (start) begin
			left <= burst;
		end
	end

	assign busy = (left != 8'h00) || pulseOut || (waitCnt != 4'h0);
endmodule

// >>> verif/swing_length_count_unit_bench.sv
// Purpose: Self-checking bench of the swing, length and count unit
// Assumes: Short swing time base of four clocks per tick
// Notes: One pulse model is routed to length, count or fast input
`timescale 1ns/1ns
module swing_length_count_unit_bench;
	logic ref_clk, reset_n, psel, penable, pwrite, lengthClear, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] setFrequencySource, outFrequency;
	logic lengthReached, setCountReached, designatedCountReached;
	logic start, pulse, busy, e;
	logic [7:0] burst;
	logic [1:0] rt;
	int fails, cmpCount;
	logic [7:0] ofs [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
	logic [15:0] rv [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h01f4, 16'h03e8, 16'h0000, 16'h03e8,
		16'h03e8, 16'h03e8, 16'h0000};

	swing_length_count_unit #(.TICK_CYCLES(4)) swing_length_count_unit_inst (.ref_clk(ref_clk),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .setFrequencySource(setFrequencySource),
		.lengthPulseInput(pulse & (rt == 2'h0)), .countPulseInput(pulse & (rt == 2'h1)),
		.highSpeedPulseInput(pulse & (rt == 2'h2)), .lengthClear(lengthClear), .outFrequency(outFrequency),
		.lengthReached(lengthReached), .setCountReached(setCountReached),
		.designatedCountReached(designatedCountReached));
	machine_pulse_model machine_pulse_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .start(start),
		.burst(burst), .gap(4'h1), .pulseOut(pulse), .busy(busy));

	////////////////////////////////////////////////////////////////
	// Clock at 20 MHz
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Count each comparison and report each mismatch
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmpCount++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// One APB transfer; idle cycle after so psel never toggles twice in a step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task rd(input logic [7:0] a, input logic [15:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, {16'h0000, x}, "register read");
	endtask

	// Fire n pulses onto the selected line and let flags settle
	task pulses(input logic [1:0] r, input logic [7:0] n);
		int k;
		k = 0;
		rt <= r;
		burst <= n;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		@(posedge ref_clk);
		while (busy && k < 200) begin
			@(posedge ref_clk);
			k++;
		end
		repeat (4) @(posedge ref_clk);
	endtask

	// Peak and trough of the output over more than two swing cycles
	task swing(input logic [15:0] hi, input logic [15:0] lo);
		logic [15:0] mx, mn;
		repeat (45) @(posedge ref_clk);
		mx = 16'h0000;
		mn = 16'hffff;
		repeat (100) begin
			@(posedge ref_clk);
			if (outFrequency > mx) mx = outFrequency;
			if (outFrequency < mn) mn = outFrequency;
		end
		chk(mx, hi, "swing peak");
		chk(mn, lo, "swing trough");
	endtask

	task test_done;
		$display("comparisons %0d mismatches %0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Watchdog well beyond the under one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		$display("unexpected at %0t: run hung", $time);
		test_done;
	end

	// Main sequence
	initial begin
		{reset_n, psel, penable, pwrite, lengthClear, start} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		burst = 8'h00;
		rt = 2'h0;
		setFrequencySource = 16'h0fa0;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 11; i++) rd(ofs[i], rv[i]);
		apb(1'b0, 8'h44, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped error");
		apb(1'b1, 8'h28, 32'h5);
		rd(8'h28, 16'h0000);
		swing(16'h0fa0, 16'h0fa0);
		apb(1'b1, 8'h0c, 32'ha);
		apb(1'b1, 8'h04, 32'h64);
		apb(1'b1, 8'h08, 32'h64);
		swing(16'h1130, 16'h0e10);
		apb(1'b1, 8'h2c, 32'h1770);
		apb(1'b1, 8'h00, 32'h1);
		swing(16'h11f8, 16'h0d48);
		apb(1'b1, 8'h30, 32'h1068);
		apb(1'b1, 8'h34, 32'h0ed8);
		swing(16'h1068, 16'h0ed8);
		apb(1'b1, 8'h20, 32'h5);
		apb(1'b1, 8'h24, 32'h3);
		pulses(2'h1, 8'h02);
		chk({setCountReached, designatedCountReached}, 2'b00, "below both counts");
		pulses(2'h1, 8'h01);
		chk({setCountReached, designatedCountReached}, 2'b01, "designated count");
		pulses(2'h1, 8'h04);
		chk({setCountReached, designatedCountReached}, 2'b11, "set count");
		rd(8'h28, 16'h0005);
		apb(1'b1, 8'h20, 32'h6);
		repeat (3) @(posedge ref_clk);
		chk(setCountReached, 1'b0, "raised set count");
		apb(1'b1, 8'h1c, 32'ha);
		apb(1'b1, 8'h14, 32'h2);
		apb(1'b1, 8'h00, 32'h6);
		pulses(2'h2, 8'h02);
		rd(8'h18, 16'h0002);
		rd(8'h28, 16'h0006);
		chk(lengthReached, 1'b0, "length equal set");
		pulses(2'h2, 8'h01);
		chk(lengthReached, 1'b1, "length above set");
		lengthClear <= 1'b1;
		@(posedge ref_clk);
		lengthClear <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(8'h18, 16'h0000);
		chk(lengthReached, 1'b0, "length cleared");
		apb(1'b1, 8'h00, 32'h0);
		pulses(2'h0, 8'h01);
		rd(8'h18, 16'h0001);
		apb(1'b1, 8'h38, 32'h3);
		rd(8'h18, 16'h0000);
		rd(8'h28, 16'h0000);
		test_done;
	end
endmodule
